// *** rtl/timer_pkg.sv ***
package timer_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int NUM_TIMERS = 4;                // two pairs of 16-bit timers
  localparam int NUM_PAIRS  = 2;
  localparam int ADC_PAIR   = 1;                // pair that owns the adc trigger

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] TIMER_STRIDE = 8'h10;  // one block of four words per timer, three of them used
  localparam logic [7:0] CTRL_OFS     = 8'h00;  // control word within a block
  localparam logic [7:0] COUNT_OFS    = 8'h04;  // count word within a block
  localparam logic [7:0] PERIOD_OFS   = 8'h08;  // period word within a block
  localparam logic [7:0] HOLD_BASE    = 8'h40;  // upper count holding, one word per pair
  localparam logic [7:0] FLAG_OFS     = 8'h48;  // period match flags, write one to clear

  // ************************************************************
  // control field positions
  // ************************************************************
  localparam int RUN_POS       = 15;
  localparam int IDLE_STOP_POS = 13;
  localparam int GATE_POS      = 6;
  localparam int PRESCALE_POS  = 4;             // two bits, 5..4
  localparam int PAIR_POS      = 3;             // lower timer only
  localparam int CLK_SRC_POS   = 1;

  // implemented bits, everything else reads zero
  localparam logic [15:0] LOWER_CTRL_MASK = 16'ha07a;
  localparam logic [15:0] UPPER_CTRL_MASK = 16'ha072;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;

  // ************************************************************
  // prescale terminal counts (ratio minus one)
  // ************************************************************
  localparam logic [7:0] DIV_1_LAST   = 8'h00;
  localparam logic [7:0] DIV_8_LAST   = 8'h07;
  localparam logic [7:0] DIV_64_LAST  = 8'h3f;
  localparam logic [7:0] DIV_256_LAST = 8'hff;

  // decoded control word
  typedef struct packed {
    logic       run;
    logic       idle_stop;
    logic       gate;
    logic [1:0] prescale;
    logic       pair;
    logic       clk_src;
  } timer_cfg_t;

  // one apb request as seen in the setup phase
  typedef struct packed {
    logic [7:0]  addr;
    logic        write;
    logic [15:0] wdata;
  } apb_req_t;

  // control word to fields
  function automatic timer_cfg_t decode_cfg(input logic [15:0] c);
    timer_cfg_t f;
    f.run       = c[RUN_POS];
    f.idle_stop = c[IDLE_STOP_POS];
    f.gate      = c[GATE_POS];
    f.prescale  = c[PRESCALE_POS +: 2];
    f.pair      = c[PAIR_POS];
    f.clk_src   = c[CLK_SRC_POS];
    return f;
  endfunction

  // prescale code to terminal count
  function automatic logic [7:0] prescale_last(input logic [1:0] code);
    logic [7:0] r;
    r = DIV_1_LAST;
    unique case (code)
      2'h0: r = DIV_1_LAST;
      2'h1: r = DIV_8_LAST;
      2'h2: r = DIV_64_LAST;
      2'h3: r = DIV_256_LAST;
    endcase
    return r;
  endfunction

endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
// two-flop synchroniser with rising edge detect on the synchronised level
module pin_sync
  import timer_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  logic meta_reg;   // first stage, read only by sync_reg
  logic sync_reg;   // second stage
  logic last_reg;   // previous synchronised level

  // ************************************************************
  // synchroniser chain
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~last_reg;

endmodule // pin_sync

// *** rtl/timer_prescaler.sv ***
`timescale 1ns/1ps
// divides a stream of input ticks by 1, 8, 64 or 256
module timer_prescaler
  import timer_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       tick_in,
  input  wire logic [1:0] prescale,
  input  wire logic       clear,
  output logic            tick_out
);

  logic [7:0] cnt_reg;   // ticks seen since last output
  logic [7:0] last;      // terminal count for the chosen ratio

  assign last     = prescale_last(prescale);
  assign tick_out = tick_in & (cnt_reg == last);

  // ************************************************************
  // divider counter
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
    end else if (clear) begin
      cnt_reg <= 8'h00;
    end else if (tick_in) begin
      cnt_reg <= (cnt_reg == last) ? 8'h00 : cnt_reg + 8'h01;
    end
  end

endmodule // timer_prescaler

// *** rtl/paired_16_32bit_timer.sv ***
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
// How it works
// - pair bit joins lower and upper timers
// - upper control ignored while paired
// - pair uses lower clock, upper flag
// - upper count holds msw, lower lsw
// - upper period msw, lower period lsw
// - pair matches on full 32-bit compare
// - run bit starts and stops counting
// - idle-stop bit halts timer in idle
// - gate bit honoured only on internal clock
// - prescale divides by 1, 8, 64, 256
// - clock source picks pin edges or mclk
// - control write while running clears prescaler
// - single timers count synchronously only
// - one pair drives the adc trigger
// - unimplemented bits zero, controls reset zero
module paired_16_32bit_timer
  import timer_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // system
  input  wire logic                  idle_mode,
  input  wire logic [NUM_TIMERS-1:0] external_clock_pin,
  output logic      [NUM_TIMERS-1:0] match_flag,
  output logic                       adc_trigger
);

  // ************************************************************
  // storage
  // ************************************************************
  logic [15:0]           ctrl_reg   [NUM_TIMERS];   // control words
  logic [15:0]           count_reg  [NUM_TIMERS];   // count words
  logic [15:0]           period_reg [NUM_TIMERS];   // period words
  logic [15:0]           hold_reg   [NUM_PAIRS];    // upper count captured on lower read
  logic [NUM_TIMERS-1:0] flag_reg;                  // sticky period match flags
  logic [31:0]           prdata_reg;                // read data, loaded in setup phase
  logic                  miss_reg;                  // setup phase hit no register
  logic                  adc_reg;                   // adc trigger pulse

  // ************************************************************
  // per-timer decoded state
  // ************************************************************
  timer_cfg_t            cfg       [NUM_TIMERS];    // fields of each control word
  logic [NUM_TIMERS-1:0] pin_level;                 // synchronised pin levels
  logic [NUM_TIMERS-1:0] pin_rise;                  // synchronised pin rising edges
  logic [NUM_TIMERS-1:0] src_tick;                  // raw counting source per timer
  logic [NUM_TIMERS-1:0] run_ok;                    // running and not idled
  logic [NUM_TIMERS-1:0] pre_clear;                 // prescaler clear request
  logic [NUM_TIMERS-1:0] cnt_tick;                  // prescaled counting tick
  logic [NUM_TIMERS-1:0] match_hit;                 // period match this tick
  logic [NUM_TIMERS-1:0] ctrl_wr;                   // control write this cycle
  logic [NUM_TIMERS-1:0] count_wr;                  // count write this cycle
  logic [NUM_TIMERS-1:0] period_wr;                 // period write this cycle
  logic [NUM_TIMERS-1:0] count_rd;                  // count read this cycle
  logic [NUM_PAIRS-1:0]  paired;                    // pair bit of each lower timer
  logic                  flag_wr;                   // flag clear write this cycle

  // ************************************************************
  // apb access phase
  // ************************************************************
  apb_req_t req;                                    // request fields
  logic     access;                                 // access phase, zero wait states

  assign req.addr  = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata[15:0];
  assign access    = psel & penable;
  assign pready    = 1'b1;
  assign pslverr   = access & miss_reg;
  assign prdata    = prdata_reg;
  assign match_flag = flag_reg;
  assign adc_trigger = adc_reg;

  // address of one register of one timer
  function automatic logic [7:0] timer_addr(input int t, input logic [7:0] ofs);
    return 8'(t * TIMER_STRIDE) + ofs;
  endfunction

  // ************************************************************
  // write and read strobes
  // ************************************************************
  always_comb begin
    for (int t = 0; t < NUM_TIMERS; t++) begin
      ctrl_wr[t]   = access & req.write & (req.addr == timer_addr(t, CTRL_OFS));
      count_wr[t]  = access & req.write & (req.addr == timer_addr(t, COUNT_OFS));
      period_wr[t] = access & req.write & (req.addr == timer_addr(t, PERIOD_OFS));
      count_rd[t]  = access & ~req.write & (req.addr == timer_addr(t, COUNT_OFS));
    end
    flag_wr = access & req.write & (req.addr == FLAG_OFS);
  end

  // ************************************************************
  // pins and prescalers
  // ************************************************************
  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
    pin_sync u_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .pin   (external_clock_pin[t]),
      .level (pin_level[t]),
      .rise  (pin_rise[t])
    );

    // lower timer's settings steer the pair
    localparam int LOW = (t / 2) * 2;
    timer_cfg_t eff;
    always_comb begin
      eff = (paired[t/2] && (t % 2 == 1)) ? cfg[LOW] : cfg[t];
    end

    // source: pin edges, plain mclk, or mclk gated by the pin level
    always_comb begin
      if (eff.clk_src) begin
        src_tick[t] = pin_rise[t - (t % 2) * (paired[t/2] ? 1 : 0)];
      end else if (eff.gate) begin
        src_tick[t] = pin_level[t - (t % 2) * (paired[t/2] ? 1 : 0)];
      end else begin
        src_tick[t] = 1'b1;
      end
      run_ok[t] = eff.run & ~(eff.idle_stop & idle_mode);
    end

    // any control write during run clears this prescaler
    assign pre_clear[t] = ctrl_wr[t] & cfg[t].run;

    timer_prescaler u_pre (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .tick_in  (src_tick[t] & run_ok[t]),
      .prescale (eff.prescale),
      .clear    (pre_clear[t]),
      .tick_out (cnt_tick[t])
    );
  end

  // ************************************************************
  // control decode and pair mode
  // ************************************************************
  always_comb begin
    for (int t = 0; t < NUM_TIMERS; t++) begin
      cfg[t] = decode_cfg(ctrl_reg[t]);
    end
    for (int p = 0; p < NUM_PAIRS; p++) begin
      paired[p] = cfg[2*p].pair;
    end
  end

  // ************************************************************
  // period match detect
  // ************************************************************
  always_comb begin
    for (int p = 0; p < NUM_PAIRS; p++) begin
      if (paired[p]) begin
        // full 32-bit compare, flag lands on the upper timer
        match_hit[2*p]   = 1'b0;
        match_hit[2*p+1] = cnt_tick[2*p] &
          ({count_reg[2*p+1], count_reg[2*p]} ==
           {period_reg[2*p+1], period_reg[2*p]});
      end else begin
        match_hit[2*p]   = cnt_tick[2*p]   & (count_reg[2*p]   == period_reg[2*p]);
        match_hit[2*p+1] = cnt_tick[2*p+1] & (count_reg[2*p+1] == period_reg[2*p+1]);
      end
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        ctrl_reg[t] <= CTRL_RESET;
      end
    end else begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        if (ctrl_wr[t]) begin
          // unimplemented bits are never stored
          ctrl_reg[t] <= req.wdata & ((t % 2 == 0) ? LOWER_CTRL_MASK
                                                   : UPPER_CTRL_MASK);
        end
      end
    end
  end

  // ************************************************************
  // period registers
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        period_reg[t] <= PERIOD_RESET;
      end
    end else begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        if (period_wr[t]) begin
          period_reg[t] <= req.wdata;
        end
      end
    end
  end

  // ************************************************************
  // count registers
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        count_reg[t] <= COUNT_RESET;
      end
    end else begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        if (paired[p]) begin
          // one 32-bit counter, upper word is msw
          if (cnt_tick[2*p]) begin
            if (match_hit[2*p+1]) begin
              count_reg[2*p+1] <= COUNT_RESET;
              count_reg[2*p]   <= COUNT_RESET;
            end else begin
              {count_reg[2*p+1], count_reg[2*p]} <=
                {count_reg[2*p+1], count_reg[2*p]} + 32'h0000_0001;
            end
          end
        end else begin
          // two independent 16-bit counters
          for (int k = 2*p; k < 2*p + 2; k++) begin
            if (cnt_tick[k]) begin
              count_reg[k] <= match_hit[k] ? COUNT_RESET
                                           : count_reg[k] + 16'h0001;
            end
          end
        end
        // software writes win over a count tick
        for (int k = 2*p; k < 2*p + 2; k++) begin
          if (count_wr[k]) begin
            count_reg[k] <= req.wdata;
          end
        end
      end
    end
  end

  // ************************************************************
  // upper count holding, captured when the lower word is read
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        hold_reg[p] <= COUNT_RESET;
      end
    end else begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        if (count_rd[2*p]) begin
          hold_reg[p] <= count_reg[2*p+1];
        end
      end
    end
  end

  // ************************************************************
  // match flags, a new match beats a clear in the same cycle
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= (flag_reg & ~(flag_wr ? req.wdata[NUM_TIMERS-1:0] : '0))
                  | match_hit;
    end
  end

  // ************************************************************
  // adc trigger from the designated pair
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      adc_reg <= 1'b0;
    end else begin
      // upper timer match in both modes, the pair lands there too
      adc_reg <= match_hit[2*ADC_PAIR+1];
    end
  end

  // ************************************************************
  // read data, prepared in the setup phase
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
      miss_reg   <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg <= 32'h0000_0000;
      miss_reg   <= 1'b1;
      for (int t = 0; t < NUM_TIMERS; t++) begin
        if (req.addr == timer_addr(t, CTRL_OFS)) begin
          prdata_reg <= {16'h0000, ctrl_reg[t]};
          miss_reg   <= 1'b0;
        end
        if (req.addr == timer_addr(t, COUNT_OFS)) begin
          prdata_reg <= {16'h0000, count_reg[t]};
          miss_reg   <= 1'b0;
        end
        if (req.addr == timer_addr(t, PERIOD_OFS)) begin
          prdata_reg <= {16'h0000, period_reg[t]};
          miss_reg   <= 1'b0;
        end
      end
      for (int p = 0; p < NUM_PAIRS; p++) begin
        if (req.addr == HOLD_BASE + 8'(p * 4)) begin
          prdata_reg <= {16'h0000, hold_reg[p]};
          miss_reg   <= 1'b0;
        end
      end
      if (req.addr == FLAG_OFS) begin
        prdata_reg <= {28'h000_0000, flag_reg};
        miss_reg   <= 1'b0;
      end
    end
  end

  // software order on setup is its own concern: need
  // no hardware, a run bit set early simply starts counting at once

endmodule // paired_16_32bit_timer

// *** verif/timer_checker.sv ***
`timescale 1ns/1ps
// ************************************************************
// port watcher for the paired timer
// ************************************************************
module timer_checker
  import timer_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  idle_mode,
  input wire logic [NUM_TIMERS-1:0] external_clock_pin,
  input wire logic [NUM_TIMERS-1:0] match_flag,
  input wire logic                  adc_trigger
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic acc;  // access phase
  assign acc = psel && penable;

  a_ctrl_unused_zero: assert property (
    acc && !pwrite && paddr < 8'h40 && paddr[3:0] == 4'h0 |->
    (prdata[15:0] & ~(paddr[4] ? UPPER_CTRL_MASK : LOWER_CTRL_MASK)) == 16'h0000)
    else $error("unimplemented control bit reads one");
  a_read_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_unmapped_err: assert property (acc && paddr >= 8'h4c |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  a_flag_no_err: assert property (acc && paddr == FLAG_OFS |-> !pslverr)
    else $error("flag access refused");
  a_err_in_access: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  a_ready_high: assert property (pready)
    else $error("ready dropped");
  a_adc_after_match: assert property (adc_trigger |-> match_flag[3])
    else $error("trigger without upper match");
  a_match_fires_adc: assert property ($rose(match_flag[3]) |-> adc_trigger)
    else $error("upper match without trigger");
  a_flag_sticky: assert property (|($past(match_flag) & ~match_flag) |->
    $past(acc && pwrite && paddr == FLAG_OFS) &&
    (($past(match_flag) & ~match_flag & ~$past(pwdata[3:0])) == 4'h0))
    else $error("flag cleared without write one");
  c_adc: cover property (adc_trigger);
  c_upper_flag: cover property ($rose(match_flag[1]));
  c_refused: cover property (pslverr);
endmodule // timer_checker

bind paired_16_32bit_timer timer_checker timer_checker_inst (.mclk(mclk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
  .external_clock_pin(external_clock_pin), .match_flag(match_flag),
  .adc_trigger(adc_trigger));

// *** verif/cpu_bus_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// cpu side of the register bus
// ************************************************************
module cpu_bus_model
  import timer_pkg::*;
(
  input  wire logic        mclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one transfer; released address and data lines show inverted values
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // cpu_bus_model

// *** verif/paired_16_32bit_timer_test.sv ***
`timescale 1ns/1ps
// ************************************************************
// self-checking bench for the paired timer
// ************************************************************
module paired_16_32bit_timer_test
  import timer_pkg::*;
();
  logic                  mclk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  psel, penable, pwrite, pready, pslverr, rd_e, adc_trigger;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, rd_v, q;
  logic                  idle_mode = 1'b0;
  logic [NUM_TIMERS-1:0] ext_pin = 4'h0;
  logic [NUM_TIMERS-1:0] match_flag;
  logic [31:0]           seed = 32'h6523;
  int                    errors = 0, tests_run = 0, cyc = 0, p;

  always #20 mclk = ~mclk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    cpu_bus_model_inst.xfer(1'b1, a, {16'h0000, d}, rd_v, rd_e);
  endtask
  task automatic rd(input logic [7:0] a);
    cpu_bus_model_inst.xfer(1'b0, a, 32'h0, rd_v, rd_e);
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int ratio(input int k);
    return (k == 0) ? 1 : (k == 1) ? 8 : (k == 2) ? 64 : 256;
  endfunction
  // write control, count cycles to flag f, idle high for ic cycles
  task automatic run_wait(input logic [7:0] a, input logic [15:0] c, input int f,
                          input int ic, input int exp);
    int n;
    n = 0;
    // idle left high by an earlier scenario would freeze the first tick
    idle_mode <= 1'b0;
    wr(a, c);
    while (match_flag[f] !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
      idle_mode <= (n <= ic);
      #1;
    end
    check(n, exp);
  endtask
  task automatic wrap_up();
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      rd(8'(t * 16));
      check(rd_v, 32'h0);
      rd(8'(t * 16 + 8));
      check(rd_v, 32'h0000ffff);
      wr(8'(t * 16), 16'h7fff);
      rd(8'(t * 16));
      check(rd_v, (t % 2) ? 32'h2072 : 32'h207a);
      wr(8'(t * 16), 16'h0000);
    end
    rd(8'h4c);
    check({rd_v[30:0], rd_e}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      seed = nxt(seed);
      p = seed[1:0] + 1;
      wr(8'h08, 16'(p));
      wr(8'h04, 16'h0);
      wr(FLAG_OFS, 16'hf);
      run_wait(8'h00, 16'h8000 | 16'(k << 4), 0, 0, (p + 1) * ratio(k));
      wr(8'h00, 16'h0);
      rd(8'h04);
      q = rd_v;
      repeat (5) @(posedge mclk);
      rd(8'h04);
      check(rd_v, q);
    end
    for (int s = 0; s < 2; s++) begin
      seed = nxt(seed);
      p = seed[2:0] + 2;
      wr(8'h18, 16'(p));
      wr(8'h14, 16'h0);
      wr(FLAG_OFS, 16'hf);
      run_wait(8'h10, s ? 16'ha000 : 16'h8000, 1, 9, p + 1 + (s ? 9 : 0));
      wr(8'h10, 16'h0);
    end
    wr(8'h08, 16'h0);
    wr(8'h04, 16'h0);
    wr(FLAG_OFS, 16'hf);
    wr(8'h00, 16'h8010);
    run_wait(8'h00, 16'h8010, 0, 0, 8);
    wr(FLAG_OFS, 16'hf);
    wr(8'h00, 16'h8040);
    repeat (30) @(posedge mclk);
    check(match_flag, 32'h0);
    ext_pin[0] <= 1'b1;
    repeat (12) @(posedge mclk);
    check(match_flag[0], 1'b1);
    wr(8'h00, 16'h0);
    seed = nxt(seed);
    p = seed[1:0] + 1;
    wr(8'h18, 16'(p));
    wr(8'h14, 16'h0);
    wr(FLAG_OFS, 16'hf);
    wr(8'h10, 16'h8042);
    for (int i = 0; i <= p; i++) begin
      check(match_flag[1], 1'b0);
      ext_pin[1] <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_pin[1] <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    check(match_flag[1], 1'b1);
    wr(8'h10, 16'h0);
    wr(8'h20, 16'h0008);
    wr(8'h30, 16'h8030);
    seed = nxt(seed);
    wr(8'h34, seed[15:0]);
    rd(8'h24);
    rd(8'h44);
    check(rd_v, {16'h0, seed[15:0]});
    wr(8'h34, 16'h0);
    wr(8'h24, 16'hfffe);
    wr(8'h28, 16'h0003);
    wr(8'h38, 16'h0001);
    wr(FLAG_OFS, 16'hf);
    run_wait(8'h20, 16'h8008, 3, 0, 6);
    check(match_flag[2], 1'b0);
    // trigger pulse is registered on the same edge as the flag
    check(adc_trigger, 1'b1);
    wrap_up();
  end

  cpu_bus_model cpu_bus_model_inst (.mclk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  paired_16_32bit_timer paired_16_32bit_timer_inst (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
    .external_clock_pin(ext_pin), .match_flag(match_flag), .adc_trigger(adc_trigger));
endmodule // paired_16_32bit_timer_test
